// [hdl/qtm_defines.svh]
// Register offsets, field positions and divider constants of the quad timer
`ifndef QTM_DEFINES_SVH
`define QTM_DEFINES_SVH
// Printed mode register offsets are word indices
`define QTM_IDX_MODE_A 8'hd0
`define QTM_IDX_MODE_B 8'hd2
`define QTM_IDX_MODE_C 8'hd6
`define QTM_IDX_MODE_D 8'hd8
`define QTM_ADDR_MATCH0 12'h000
`define QTM_ADDR_COUNT 12'h010
`define QTM_ADDR_STATUS 12'h014
`define QTM_ADDR_MASK 12'h018
`define QTM_B_RESTART 0
`define QTM_B_RUN 1
`define QTM_CK_LSB 2
`define QTM_B_CAP_LO 5
`define QTM_B_CAP_HI 4
`define QTM_B_PWM 5
`define QTM_B_JOIN 6
`define QTM_B_DUTY 7
`define QTM_MODE_LO_MASK 8'h3f
`define QTM_MODE_HI_MASK 8'hff
`define QTM_MODE_RST 8'h00
`define QTM_DIV_W 11
// Log2 of divide ratio per clock select code, code 0 in the low nibble
`define QTM_LG_A 28'hb975321
`define QTM_LG_C 28'ha864321
`define QTM_LG_B 12'h420
`define QTM_EXT_CODE 3'h7
`define QTM_CHAIN_CODE 2'h3
`endif

// [hdl/qtm_pkg.sv]
// Types shared by the quad timer mode control
package qtm_pkg;
  typedef struct packed {
    logic [3:0] capture_sel;
    logic [1:0] pulse_width_enable;
    logic [1:0] duty_level_select;
    logic [1:0] pair_join;
  } qtm_mode_t;
endpackage

// [hdl/qtm_timer_ctrl.sv]
// Quad 8-bit timer mode control with APB registers and match interrupt
//
// How it works
// - capture bit selects capture or timer mode
// - timer a select codes pick prescaler or pin
// - timer c select codes pick prescaler or pin
// - timer b selects 1, 4, 16 or chain
// - run bit zero pauses the counter
// - restart write clears count; zero stops
// - duty level bit sets pair PWM polarity
// - join bit makes a pair 16-bit
// - upper PWM enable bit gates PWM
// - mode registers reset to zero
// - timer d selects 1, 4, 16 or chain
// - count to match, wrap, set flag
// - external pin counts rising edges
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "qtm_defines.svh"
module qtm_timer_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin_a,
  input wire logic ext_count_pin_c,
  output logic irq,
  output var qtm_pkg::qtm_mode_t mode_out
);
  localparam logic [11:0] MODE_ADDR [4] = '{
    {2'h0, `QTM_IDX_MODE_A, 2'h0}, {2'h0, `QTM_IDX_MODE_B, 2'h0},
    {2'h0, `QTM_IDX_MODE_C, 2'h0}, {2'h0, `QTM_IDX_MODE_D, 2'h0}};
  localparam logic [27:0] LG_LO [2] = '{`QTM_LG_A, `QTM_LG_C};
  localparam logic [11:0] LG_HI = `QTM_LG_B;

  logic [7:0] mode_r [4];
  logic [7:0] mode_nxt [4];
  logic [7:0] match_r [4];
  logic [7:0] match_nxt [4];
  logic [7:0] cnt_r [4];
  logic [7:0] cnt_nxt [4];
  logic [3:0] status_r, status_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic pready_r, pready_nxt;
  logic err_r, err_nxt;
  logic [`QTM_DIV_W-1:0] div_r, div_nxt;
  logic [5:0] sync_r, sync_nxt;
  logic [3:0] tick;
  logic [3:0] hit;
  logic [3:0] mode_wr;
  logic [1:0] ext_edge;
  logic wr_take, rd_take;

  function automatic logic div_tick(input logic [`QTM_DIV_W-1:0] d, input logic [3:0] lg);
    logic [`QTM_DIV_W-1:0] m;
    m = ~({`QTM_DIV_W{1'b1}} << lg);
    return (d & m) == m;
  endfunction

  assign wr_take = psel & penable & pready_r & pwrite;
  assign rd_take = psel & penable & pready_r & ~pwrite;
  assign prdata = rdata_r;
  assign pready = pready_r;
  assign pslverr = err_r;
  assign irq = |(status_r & mask_r);
  // Second stage feeds the edge detector; first stage is left alone
  assign ext_edge[0] = sync_r[1] & ~sync_r[2];
  assign ext_edge[1] = sync_r[4] & ~sync_r[5];

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      mode_out.capture_sel[2*p] = mode_r[2*p][`QTM_B_CAP_LO];
      mode_out.capture_sel[2*p+1] = mode_r[2*p+1][`QTM_B_CAP_HI];
      mode_out.pulse_width_enable[p] = mode_r[2*p+1][`QTM_B_PWM];
      mode_out.duty_level_select[p] = mode_r[2*p+1][`QTM_B_DUTY];
      mode_out.pair_join[p] = mode_r[2*p+1][`QTM_B_JOIN];
    end
  end

  // Clock select: one free-running divider serves every ratio
  always_comb begin
    logic [2:0] sl;
    logic [1:0] sh;
    sl = 3'h0;
    sh = 2'h0;
    div_nxt = div_r + `QTM_DIV_W'(1);
    sync_nxt = {sync_r[4:3], ext_count_pin_c, sync_r[1:0], ext_count_pin_a};
    for (int p = 0; p < 2; p++) begin
      sl = mode_r[2*p][`QTM_CK_LSB+2:`QTM_CK_LSB];
      sh = mode_r[2*p+1][`QTM_CK_LSB+1:`QTM_CK_LSB];
      if (sl == `QTM_EXT_CODE) begin
        tick[2*p] = ext_edge[p];
      end else begin
        tick[2*p] = div_tick(div_r, LG_LO[p][{sl, 2'h0} +: 4]);
      end
      // Chain code borrows the lower timer's clock; joined mode runs on that clock whatever this code is
      if (sh == `QTM_CHAIN_CODE) begin
        tick[2*p+1] = tick[2*p];
      end else begin
        tick[2*p+1] = div_tick(div_r, LG_HI[{sh, 2'h0} +: 4]);
      end
    end
  end

  // Counters: 8-bit each, or a joined 16-bit pair driven by the lower timer
  always_comb begin
    logic en;
    logic [15:0] v16;
    logic [15:0] m16;
    logic [15:0] n16;
    en = 1'b0;
    v16 = 16'h0;
    m16 = 16'h0;
    n16 = 16'h0;
    hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = cnt_r[i];
      mode_wr[i] = wr_take && (paddr == MODE_ADDR[i]);
      en = tick[i] & mode_r[i][`QTM_B_RUN] & mode_r[i][`QTM_B_RESTART];
      if (mode_wr[i] && pwdata[`QTM_B_RESTART]) begin
        cnt_nxt[i] = 8'h00;
      end else if (en) begin
        if (cnt_r[i] == match_r[i]) begin
          cnt_nxt[i] = 8'h00;
          hit[i] = 1'b1;
        end else begin
          cnt_nxt[i] = cnt_r[i] + 8'h01;
        end
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (mode_r[2*p+1][`QTM_B_JOIN]) begin
        hit[2*p] = 1'b0;
        hit[2*p+1] = 1'b0;
        v16 = {cnt_r[2*p+1], cnt_r[2*p]};
        m16 = {match_r[2*p+1], match_r[2*p]};
        n16 = v16;
        en = tick[2*p] & mode_r[2*p][`QTM_B_RUN] & mode_r[2*p][`QTM_B_RESTART];
        if (mode_wr[2*p] && pwdata[`QTM_B_RESTART]) begin
          n16 = 16'h0000;
        end else if (en) begin
          if (v16 == m16) begin
            n16 = 16'h0000;
            hit[2*p] = 1'b1;
          end else begin
            n16 = v16 + 16'h0001;
          end
        end
        cnt_nxt[2*p] = n16[7:0];
        cnt_nxt[2*p+1] = n16[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cnt_r[i] <= 8'h00;
      end
      div_r <= '0;
      sync_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      sync_r <= sync_nxt;
    end
  end

  // Register file; read data is captured in setup so the access has no wait
  always_comb begin
    logic hit_addr;
    logic [3:0] rd_clr;
    hit_addr = 1'b0;
    rd_clr = 4'h0;
    mode_nxt = mode_r;
    match_nxt = match_r;
    mask_nxt = mask_r;
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    pready_nxt = psel & ~penable;
    if (psel && !penable) begin
      rdata_nxt = 32'h0;
      for (int i = 0; i < 4; i++) begin
        if (paddr == MODE_ADDR[i]) begin
          hit_addr = 1'b1;
          rdata_nxt[7:0] = mode_r[i];
        end
        if (paddr == `QTM_ADDR_MATCH0 + 12'(4 * i)) begin
          hit_addr = 1'b1;
          rdata_nxt[7:0] = match_r[i];
        end
      end
      if (paddr == `QTM_ADDR_COUNT) begin
        hit_addr = 1'b1;
        rdata_nxt = {cnt_r[3], cnt_r[2], cnt_r[1], cnt_r[0]};
      end
      if (paddr == `QTM_ADDR_STATUS) begin
        hit_addr = 1'b1;
        rdata_nxt[3:0] = status_r;
      end
      if (paddr == `QTM_ADDR_MASK) begin
        hit_addr = 1'b1;
        rdata_nxt[3:0] = mask_r;
      end
      if (pwrite) begin
        rdata_nxt = 32'h0;
      end
      err_nxt = ~hit_addr;
    end
    if (wr_take) begin
      for (int i = 0; i < 4; i++) begin
        if (paddr == MODE_ADDR[i]) begin
          mode_nxt[i] = pwdata[7:0] & ((i % 2 == 0) ? `QTM_MODE_LO_MASK : `QTM_MODE_HI_MASK);
        end
        if (paddr == `QTM_ADDR_MATCH0 + 12'(4 * i)) begin
          match_nxt[i] = pwdata[7:0];
        end
      end
      if (paddr == `QTM_ADDR_MASK) begin
        mask_nxt = pwdata[3:0];
      end
    end
    // Only bits that were reported are cleared, and a new hit wins
    if (rd_take && paddr == `QTM_ADDR_STATUS) begin
      rd_clr = rdata_r[3:0];
    end
    status_nxt = (status_r & ~rd_clr) | hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= `QTM_MODE_RST;
        match_r[i] <= 8'h00;
      end
      mask_r <= 4'h0;
      status_r <= 4'h0;
      rdata_r <= 32'h0;
      pready_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      match_r <= match_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      pready_r <= pready_nxt;
      err_r <= err_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_capture_write: assert property (mode_wr[0] |=>
    mode_out.capture_sel[0] == $past(pwdata[`QTM_B_CAP_LO]))
    else $error("capture select does not follow write");
  chk_tick_gate_a: assert property (!tick[0] && !mode_wr[0] &&
    !mode_r[1][`QTM_B_JOIN] |=> cnt_r[0] == $past(cnt_r[0]))
    else $error("timer a moved without a tick");
  chk_tick_gate_c: assert property (!tick[2] && !mode_wr[2] &&
    !mode_r[3][`QTM_B_JOIN] |=> cnt_r[2] == $past(cnt_r[2]))
    else $error("timer c moved without a tick");
  chk_undivided_b: assert property (mode_r[1][3:0] == 4'h3 &&
    !mode_r[1][`QTM_B_JOIN] && !mode_wr[1] && cnt_r[1] != match_r[1]
    |=> cnt_r[1] == $past(cnt_r[1]) + 8'h01)
    else $error("undivided timer b failed to step");
  chk_pause_hold: assert property (!mode_r[0][`QTM_B_RUN] && !mode_wr[0] &&
    !mode_r[1][`QTM_B_JOIN] |=> $stable(cnt_r[0]))
    else $error("paused timer a advanced");
  chk_restart_clear: assert property (mode_wr[2] && pwdata[`QTM_B_RESTART]
    |=> cnt_r[2] == 8'h00 ##1 mode_r[2][`QTM_B_RESTART])
    else $error("restart did not clear timer c");
  // Reset itself is the antecedent, so the default disable must not mask it
  chk_reset_modes: assert property (@(posedge pclk) disable iff (1'b0) !presetn |->
    mode_r[0] == 8'h00 && mode_r[1] == 8'h00 && mode_r[2] == 8'h00 && mode_r[3] == 8'h00)
    else $error("mode registers not zero in reset");
  chk_match_wrap: assert property (tick[1] && mode_r[1][1:0] == 2'h3 &&
    !mode_r[1][`QTM_B_JOIN] && !mode_wr[1] && cnt_r[1] == match_r[1]
    |=> cnt_r[1] == 8'h00 && status_r[1])
    else $error("timer b match did not wrap and flag");
  chk_join_carry: assert property (mode_r[1][`QTM_B_JOIN] && tick[0] &&
    mode_r[0][1:0] == 2'h3 && !mode_wr[0] && cnt_r[0] == 8'hff &&
    {cnt_r[1], cnt_r[0]} != {match_r[1], match_r[0]}
    |=> cnt_r[0] == 8'h00 && cnt_r[1] == $past(cnt_r[1]) + 8'h01)
    else $error("joined pair did not carry");
  chk_ext_edge: assert property (mode_r[0][4:0] == 5'h1f && sync_r[1] && !sync_r[2] &&
    !mode_r[1][`QTM_B_JOIN] && !mode_wr[0] && cnt_r[0] != match_r[0]
    |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
    else $error("pin edge did not step timer a");
  chk_irq_level: assert property ($rose(status_r[0]) && mask_r[0] |-> irq)
    else $error("unmasked flag did not raise irq");

  cov_joined_match: cover property (mode_r[1][`QTM_B_JOIN] && hit[0]);
  cov_ext_count: cover property (ext_edge[0] && tick[0]);
  cov_status_clear: cover property (rd_take && paddr == `QTM_ADDR_STATUS && rdata_r[0]);
  cov_pulse_mode: cover property (mode_out.pulse_width_enable[1] && hit[3]);
endmodule
`default_nettype wire

// [hdl/qtm_empty_placeholder_none.sv]
// Intentionally empty compilation unit marker
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [dv/testbench.sv]
// Register-level testbench for the quad timer mode control
`timescale 1ns/10ps
`default_nettype none
`include "qtm_defines.svh"
module testbench;
  localparam logic [11:0] MA = {2'b00, `QTM_IDX_MODE_A, 2'b00};
  localparam logic [11:0] MB = {2'b00, `QTM_IDX_MODE_B, 2'b00};
  localparam logic [11:0] MC = {2'b00, `QTM_IDX_MODE_C, 2'b00};
  localparam logic [11:0] MD = {2'b00, `QTM_IDX_MODE_D, 2'b00};
  // Ceiling well above the roughly 2000 cycles the tests need
  localparam int LIMIT = 6000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic ext_count_pin_a, ext_count_pin_c;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, keep;
  qtm_pkg::qtm_mode_t mode_out;
  int err_count, num_checks;
  int cyc = 0;
  logic [11:0] t_addr[8] = '{MA, MA, MC, MC, MB, MB, MD, MD};
  int t_sh[8] = '{0, 0, 16, 16, 8, 8, 24, 24};
  logic [2:0] t_code[8] = '{3'h0, 3'h3, 3'h3, 3'h4, 3'h1, 3'h2, 3'h0, 3'h1};
  int t_div[8] = '{2, 32, 16, 64, 4, 16, 1, 4};
  qtm_timer_ctrl i_qtm_timer_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin_a(ext_count_pin_a),
    .ext_count_pin_c(ext_count_pin_c), .irq(irq), .mode_out(mode_out));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Hold the request until pready is seen high, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  initial begin
    {psel, penable, pwrite, ext_count_pin_a, ext_count_pin_c} = '0;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd("mode a reset", MA, 32'h0);
    rd("mode b reset", MB, 32'h0);
    rd("mode c reset", MC, 32'h0);
    rd("mode d reset", MD, 32'h0);
    rd("status reset", `QTM_ADDR_STATUS, 32'h0);
    chk("mode_out reset", 32'h0, 32'(mode_out));
    $display("test reset done");
    wr(MA, 32'hff);
    rd("mode a mask", MA, 32'h3f);
    wr(MC, 32'hff);
    rd("mode c mask", MC, 32'h3f);
    wr(MB, 32'hff);
    rd("mode b rw", MB, 32'hff);
    wr(MA, 32'h20);
    wr(MB, 32'h40);
    wr(MC, 32'h00);
    wr(MD, 32'ha0);
    // The last write lands on the edge just passed; look once it has settled
    @(posedge pclk);
    chk("mode_out fields", 32'h069, 32'(mode_out));
    wr(MA, 32'h0);
    wr(MB, 32'h0);
    wr(MD, 32'h0);
    xfer(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", 32'h1, 32'(rerr));
    $display("test fields done");
    wr(`QTM_ADDR_MATCH0 + 12'h4, 32'h2);
    wr(`QTM_ADDR_MASK, 32'h2);
    xfer(1'b0, `QTM_ADDR_STATUS, 32'h0);
    wr(MB, 32'h03);
    repeat (8) @(posedge pclk);
    wr(MB, 32'h02);
    chk("irq after wrap", 32'h1, 32'(irq));
    xfer(1'b0, `QTM_ADDR_COUNT, 32'h0);
    chk("count b bound", 32'h1, 32'(rdat[15:8] <= 8'h02));
    rd("status wrap", `QTM_ADDR_STATUS, 32'h2);
    @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    rd("status cleared", `QTM_ADDR_STATUS, 32'h0);
    $display("test wrap done");
    wr(`QTM_ADDR_MATCH0 + 12'h4, 32'hff);
    wr(MB, 32'h03);
    repeat (20) @(posedge pclk);
    wr(MB, 32'h00);
    xfer(1'b0, `QTM_ADDR_COUNT, 32'h0);
    keep = rdat;
    chk("count advanced", 32'h1, 32'(keep[15:8] > 8'h10));
    repeat (10) @(posedge pclk);
    rd("count stopped", `QTM_ADDR_COUNT, keep);
    wr(MB, 32'h01);
    repeat (5) @(posedge pclk);
    rd("count restart paused", `QTM_ADDR_COUNT, 32'h0);
    $display("test pause done");
    foreach (t_addr[i]) wr(12'(4 * (t_sh[i] / 8)), 32'hff);
    foreach (t_addr[i]) begin
      wr(t_addr[i], {27'h0, t_code[i], 2'b11});
      repeat (128) @(posedge pclk);
      wr(t_addr[i], {27'h0, t_code[i], 2'b10});
      xfer(1'b0, `QTM_ADDR_COUNT, 32'h0);
      keep = (rdat >> t_sh[i]) & 32'hff;
      chk("prescale count", 32'(130 / t_div[i]),
        (keep + 2 >= 130 / t_div[i] && keep <= 130 / t_div[i] + 2) ? 32'(130 / t_div[i]) : keep);
    end
    $display("test prescale done");
    for (int p = 0; p < 2; p++) begin
      wr(p ? MC : MA, 32'h1f);
      repeat (5) begin
        if (p) ext_count_pin_c <= 1'b1;
        else ext_count_pin_a <= 1'b1;
        repeat (3) @(posedge pclk);
        if (p) ext_count_pin_c <= 1'b0;
        else ext_count_pin_a <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      wr(p ? MC : MA, 32'h1e);
      xfer(1'b0, `QTM_ADDR_COUNT, 32'h0);
      chk("pin edge count", 32'h5, (rdat >> (p ? 16 : 0)) & 32'hff);
    end
    $display("test pin done");
    // Joined pair: match 0x0104 lies beyond what timer a alone could reach
    wr(`QTM_ADDR_MATCH0, 32'h04);
    wr(`QTM_ADDR_MATCH0 + 12'h4, 32'h01);
    xfer(1'b0, `QTM_ADDR_STATUS, 32'h0);
    wr(MB, 32'h4c);
    wr(MA, 32'h03);
    repeat (300) @(posedge pclk);
    xfer(1'b0, `QTM_ADDR_COUNT, 32'h0);
    chk("joined count", 32'h1, 32'(rdat[15:0] > 16'h0080 && rdat[15:0] <= 16'h0104));
    repeat (300) @(posedge pclk);
    wr(MA, 32'h02);
    rd("joined flag", `QTM_ADDR_STATUS, 32'h1);
    $display("test join done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
